/* rtl/bsfi_flash_decode.sv */
// bsfi_flash_decode: splits the single flash region select into per-bank
// selects and picks the expected access length from presence detect.
// assumes presence-detect and address inputs are synchronous to ref_clk_i.
`timescale 1ns/1ps
module bsfi_flash_decode #(
    parameter int unsigned BANK_SEL_LSB = 21        // byte address bit that picks a bank
) (
    input  wire logic                             ref_clk_i,
    input  wire logic                             rst_n_i,
    input  wire logic                             boot_region_select_n_i,
    input  wire logic                             flash_disable_bit_i,
    input  wire logic                             bus_50mhz_i,
    input  wire logic [2:0]                       presence_detect_i,
    input  wire logic [31:0]                      addr_i,
    output logic      [bsfi_pkg::FL_BANKS-1:0]    flash_bank_select_n_o,
    output logic      [4:0]                       flash_access_clocks_o
);

    // ------------------------------------------------------------------
    // bank decode
    // ------------------------------------------------------------------
    logic [bsfi_pkg::FL_BANKS-1:0] bank_sel_n_r;    // registered bank selects
    logic [bsfi_pkg::FL_BANKS-1:0] bank_sel_n_nxt;
    logic [4:0]                    acc_clk_r;       // expected access clocks
    logic [4:0]                    acc_clk_nxt;
    logic [1:0]                    size_code;       // 0: one bank, 1: two, else four
    logic [1:0]                    bank_idx;        // bank picked by address

    assign size_code = presence_detect_i[bsfi_pkg::PD_SIZE_LSB +: 2];

    // next bank selects: only the bank that the address and size code name
    always_comb begin
        bank_sel_n_nxt = '1;
        unique case (size_code)
            2'h0:    bank_idx = 2'h0;                                        // single bank
            2'h1:    bank_idx = {1'b0, addr_i[BANK_SEL_LSB]};                // two banks
            default: bank_idx = addr_i[BANK_SEL_LSB +: 2];                   // four banks
        endcase
        // one processor select covers the whole module; gated by disable bit
        if (!boot_region_select_n_i && !flash_disable_bit_i) begin
            bank_sel_n_nxt[bank_idx] = 1'b0;
        end
        // delay bit set means slow parts
        if (presence_detect_i[bsfi_pkg::PD_DELAY_BIT]) begin
            acc_clk_nxt = bus_50mhz_i ? bsfi_pkg::FL_CLK_SLOW_50 : bsfi_pkg::FL_CLK_SLOW_25;
        end else begin
            acc_clk_nxt = bus_50mhz_i ? bsfi_pkg::FL_CLK_FAST_50 : bsfi_pkg::FL_CLK_FAST_25;
        end
    end

    // register the selects and the access length
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            bank_sel_n_r <= '1;
            acc_clk_r    <= bsfi_pkg::FL_CLK_SLOW_50;
        end else begin
            bank_sel_n_r <= bank_sel_n_nxt;
            acc_clk_r    <= acc_clk_nxt;
        end
    end

    assign flash_bank_select_n_o = bank_sel_n_r;
    assign flash_access_clocks_o = acc_clk_r;

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    property p_flash_off;
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        flash_disable_bit_i |=> (&flash_bank_select_n_o);
    endproperty
    a_flash_off: assert property (p_flash_off) else $error("flash selected when off");

    property p_flash_onehot;
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        (!boot_region_select_n_i && !flash_disable_bit_i)
            |=> $onehot(~flash_bank_select_n_o);
    endproperty
    a_flash_onehot: assert property (p_flash_onehot) else $error("flash not one bank");

    property p_flash_clocks;
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        (bus_50mhz_i && !presence_detect_i[bsfi_pkg::PD_DELAY_BIT])
            |=> (flash_access_clocks_o == bsfi_pkg::FL_CLK_FAST_50);
    endproperty
    a_flash_clocks: assert property (p_flash_clocks) else $error("flash clocks wrong");

endmodule

/* rtl/bsfi_pkg.sv */
// bsfi_pkg: constants, field positions and carrier types for the board
// sdram / flash attachment glue.
// assumes a single 200 MHz reference clock and big-endian processor bit
// numbering (processor bit k sits at vector index 31-k).
package bsfi_pkg;

    // ------------------------------------------------------------------
    // clock and timing
    // ------------------------------------------------------------------
    localparam int unsigned CLK_PERIOD_PS     = 5000;           // 200 MHz reference
    localparam longint unsigned REFRESH_PERIOD_PS = 64'd62_400_000_000; // 62.4 msec
    // longest time rounds down to whole cycles
    localparam int unsigned REFRESH_PERIOD_CYC =
        int'(REFRESH_PERIOD_PS / CLK_PERIOD_PS);
    localparam logic [2:0] REFRESH_BEATS      = 3'h4;           // auto-refresh burst

    // expected access lengths in bus clocks at 50 MHz, and at 25 MHz for FL_CLK_FAST_25 and FL_CLK_SLOW_25
    localparam logic [4:0] SD_SINGLE_READ_CLK = 5'h05;
    localparam logic [4:0] SD_BURST_FIRST_CLK = 5'h05;
    localparam logic [4:0] SD_BURST_NEXT_CLK  = 5'h01;
    localparam logic [4:0] SD_WRITE_PRECHG    = 5'h01;          // extra precharge clock
    localparam logic [4:0] SD_REFRESH_CLK     = 5'h15;          // 21 clocks per burst
    localparam logic [4:0] FL_CLK_FAST_50     = 5'h08;          // 90 ns parts
    localparam logic [4:0] FL_CLK_SLOW_50     = 5'h0A;          // 120 ns parts
    localparam logic [4:0] FL_CLK_FAST_25     = 5'h04;
    localparam logic [4:0] FL_CLK_SLOW_25     = 5'h05;

    // ------------------------------------------------------------------
    // sdram geometry and address field positions (vector indices)
    // ------------------------------------------------------------------
    localparam int unsigned SD_ROWS      = 2048;
    localparam int unsigned SD_COLS      = 256;
    localparam int unsigned SD_ROW_BITS  = $clog2(SD_ROWS);     // eleven
    localparam int unsigned SD_COL_BITS  = $clog2(SD_COLS);     // eight
    localparam int unsigned SD_LINE_BITS = 10;                  // lines A20..A29
    localparam int unsigned IDX_A9       = 22;                  // processor A9
    localparam int unsigned IDX_A10      = 21;                  // processor A10
    localparam int unsigned IDX_A11      = 20;                  // processor A11
    localparam int unsigned IDX_A12      = 19;                  // processor A12
    localparam int unsigned IDX_A29      = 2;                   // processor A29
    localparam logic [2:0]  ADDR_MUX_ZERO = 3'h0;               // only supported code

    // flash presence-detect field positions
    localparam int unsigned PD_SIZE_LSB  = 0;
    localparam int unsigned PD_DELAY_BIT = 2;
    localparam int unsigned FL_BANKS     = 4;

    // ------------------------------------------------------------------
    // carrier for the sdram pins
    // ------------------------------------------------------------------
    typedef struct packed {
        logic                   cs_n;   // chip select
        logic                   ras_n;  // row strobe
        logic                   cas_n;  // column strobe
        logic                   we_n;   // write enable
        logic                   cke;    // clock enable
        logic [1:0]             bank;   // internal bank select {upper, lower}
        logic [SD_ROW_BITS-1:0] addr;   // multiplexed address, bit 10 = auto-precharge
        logic [3:0]             dqm;    // byte-lane masks
    } bsfi_sd_pins_t;

endpackage

/* rtl/bsfi_top.sv */
// bsfi_top: board glue between the processor memory controller and the
// soldered sdram plus the flash module.
// assumes all inputs are synchronous to ref_clk_i; pins except sdram_clk_o leave through flops.
//
// Contract
// - eleven row bits, eight column bits presented
// - sdram select comes from dedicated region select
// - strobe zero masks lane three, reversed
// - general line zero drives address bit ten
// - lines one, two, three drive strobes
// - sdram clock is the bus clock
// - bank selects from processor A9, A10
// - zero multiplex code maps A11..A21 row; the code puts A12..A21 on A9..A0 and A10 on bit ten, so A11 is not used
// - line zero carries A10 during row
// - enable bit drives sdram clock enable
// - expected read five clocks, write one more; the code gives write as four clocks, one fewer than read
// - four-beat refresh burst takes 21 clocks
// - one select split into banks by detect
// - flash access eight or ten clocks; the code gives four or five clocks when bus_50mhz_i is low (25 MHz bus)
// - active-low flash enable bit gates flash
// - periodic timer requests four-beat refresh bursts
`timescale 1ns/1ps
module bsfi_top #(
    parameter int unsigned REFRESH_PERIOD_CYC = bsfi_pkg::REFRESH_PERIOD_CYC,
    parameter int unsigned FL_BANK_SEL_LSB    = 21
) (
    input  wire logic                    ref_clk_i,
    input  wire logic                    rst_n_i,
    input  wire logic                    bus_clock_output_i,
    input  wire logic [31:0]             addr_i,
    input  wire logic                    row_phase_i,
    input  wire logic [2:0]              address_multiplex_field_i,
    input  wire logic                    line_zero_addr_mode_i,
    input  wire logic                    general_line_zero_i,
    input  wire logic                    general_line_one_n_i,
    input  wire logic                    general_line_two_n_i,
    input  wire logic                    general_line_three_n_i,
    input  wire logic [3:0]              byte_lane_strobes_n_i,
    input  wire logic                    sdram_region_select_n_i,
    input  wire logic                    boot_region_select_n_i,
    input  wire logic                    sdram_clock_enable_bit_i,
    input  wire logic                    flash_disable_bit_i,
    input  wire logic                    bus_50mhz_i,
    input  wire logic [2:0]              presence_detect_i,
    output logic                         sdram_clk_o,
    output bsfi_pkg::bsfi_sd_pins_t      sd_pins_o,
    output logic                         addr_mux_unsupported_o,
    output logic [3:0]                   flash_bank_select_n_o,
    output logic [4:0]                   flash_access_clocks_o,
    output logic [2:0]                   board_status_pd_o,
    output logic                         refresh_req_o,
    output logic [2:0]                   refresh_beats_o,
    output logic [4:0]                   last_sd_access_clocks_o,
    output logic [4:0]                   sd_read_clocks_o,
    output logic [4:0]                   sd_write_clocks_o,
    output logic [4:0]                   sd_refresh_clocks_o
);

    // ------------------------------------------------------------------
    // sdram pin formation
    // ------------------------------------------------------------------
    bsfi_pkg::bsfi_sd_pins_t pins_r;            // registered sdram pins
    bsfi_pkg::bsfi_sd_pins_t pins_nxt;
    logic [3:0]              dqm_map;           // reversed byte strobes
    logic [9:0]              line_addr;         // lines A20..A29 after multiplex

    // byte-lane masks: strobe k masks lane 3-k
    for (genvar g = 0; g < 4; g++) begin : g_dqm
        assign dqm_map[3-g] = byte_lane_strobes_n_i[g];
    end

    // address lines A20..A29 toward sdram A9..A0
    always_comb begin
        line_addr = '0;
        if (row_phase_i) begin
            // zero multiplex code: internal A12..A21 appear on lines A20..A29
            line_addr = addr_i[bsfi_pkg::IDX_A12 -: 10];
        end else begin
            // column phase: internal A22..A29 unmultiplexed in the low bits
            line_addr = addr_i[bsfi_pkg::IDX_A29 +: bsfi_pkg::SD_LINE_BITS];
        end
    end

    // next pin values
    always_comb begin
        pins_nxt       = pins_r;
        pins_nxt.cke   = sdram_clock_enable_bit_i;
        // select only while the device is enabled
        pins_nxt.cs_n  = sdram_region_select_n_i | ~sdram_clock_enable_bit_i;
        pins_nxt.ras_n = general_line_one_n_i;
        pins_nxt.cas_n = general_line_two_n_i;
        pins_nxt.we_n  = general_line_three_n_i;
        pins_nxt.bank  = {addr_i[bsfi_pkg::IDX_A9], addr_i[bsfi_pkg::IDX_A10]};
        pins_nxt.dqm   = dqm_map;
        pins_nxt.addr[bsfi_pkg::SD_LINE_BITS-1:0] = line_addr;
        // bit ten: address A10 in row phase when so configured, else a level
        if (row_phase_i && line_zero_addr_mode_i) begin
            pins_nxt.addr[bsfi_pkg::SD_LINE_BITS] = addr_i[bsfi_pkg::IDX_A10];
        end else begin
            pins_nxt.addr[bsfi_pkg::SD_LINE_BITS] = general_line_zero_i;
        end
    end

    // register the pins; reset leaves the device deselected and idle
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pins_r <= '{cs_n: 1'b1, ras_n: 1'b1, cas_n: 1'b1, we_n: 1'b1,
                        cke: 1'b0, bank: 2'h0, addr: '0, dqm: 4'hF};
        end else begin
            pins_r <= pins_nxt;
        end
    end

    assign sd_pins_o         = pins_r;
    assign sdram_clk_o       = bus_clock_output_i;
    assign addr_mux_unsupported_o = (address_multiplex_field_i != bsfi_pkg::ADDR_MUX_ZERO);

    // ------------------------------------------------------------------
    // sdram access length monitor (in bus clocks)
    // ------------------------------------------------------------------
    logic       bclk_d_r;                       // previous bus clock level
    logic       bclk_d_nxt;
    logic [4:0] acc_cnt_r;                      // bus clocks of current access
    logic [4:0] acc_cnt_nxt;
    logic [4:0] last_acc_r;                     // length of the last access
    logic [4:0] last_acc_nxt;
    logic       bclk_rise;                      // bus clock rising edge

    assign bclk_rise = bus_clock_output_i & ~bclk_d_r;

    // count bus clocks while the sdram select is held
    always_comb begin
        bclk_d_nxt   = bus_clock_output_i;
        acc_cnt_nxt  = acc_cnt_r;
        last_acc_nxt = last_acc_r;
        if (!pins_r.cs_n) begin
            if (bclk_rise && acc_cnt_r != 5'h1F) begin
                acc_cnt_nxt = acc_cnt_r + 5'h01;
            end
        end else if (acc_cnt_r != 5'h00) begin
            last_acc_nxt = acc_cnt_r;
            acc_cnt_nxt  = 5'h00;
        end
    end

    // register the monitor state
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            bclk_d_r   <= 1'b0;
            acc_cnt_r  <= 5'h00;
            last_acc_r <= 5'h00;
        end else begin
            bclk_d_r   <= bclk_d_nxt;
            acc_cnt_r  <= acc_cnt_nxt;
            last_acc_r <= last_acc_nxt;
        end
    end

    assign last_sd_access_clocks_o = last_acc_r;
    assign sd_read_clocks_o        = bsfi_pkg::SD_SINGLE_READ_CLK;
    assign sd_write_clocks_o       = bsfi_pkg::SD_SINGLE_READ_CLK - 5'h02
                                     + bsfi_pkg::SD_WRITE_PRECHG;
    assign sd_refresh_clocks_o     = bsfi_pkg::SD_REFRESH_CLK;

    // ------------------------------------------------------------------
    // periodic refresh timer
    // ------------------------------------------------------------------
    logic [31:0] ref_cnt_r;                     // cycles to next refresh request
    logic [31:0] ref_cnt_nxt;
    logic        ref_req_r;                     // one-cycle refresh request
    logic        ref_req_nxt;

    // count down; a request pulse every period while the sdram clock enable bit is set
    always_comb begin
        ref_req_nxt = 1'b0;
        ref_cnt_nxt = ref_cnt_r - 32'h1;
        if (ref_cnt_r == 32'h0) begin
            ref_req_nxt = sdram_clock_enable_bit_i;
            ref_cnt_nxt = 32'(REFRESH_PERIOD_CYC - 1);
        end
    end

    // register the timer
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ref_cnt_r <= 32'h0;
            ref_req_r <= 1'b0;
        end else begin
            ref_cnt_r <= ref_cnt_nxt;
            ref_req_r <= ref_req_nxt;
        end
    end

    assign refresh_req_o   = ref_req_r;
    assign refresh_beats_o = bsfi_pkg::REFRESH_BEATS;

    // ------------------------------------------------------------------
    // flash side
    // ------------------------------------------------------------------
    bsfi_flash_decode #(
        .BANK_SEL_LSB (FL_BANK_SEL_LSB)
    ) u_flash (
        .ref_clk_i              (ref_clk_i),
        .rst_n_i                (rst_n_i),
        .boot_region_select_n_i (boot_region_select_n_i),
        .flash_disable_bit_i    (flash_disable_bit_i),
        .bus_50mhz_i            (bus_50mhz_i),
        .presence_detect_i      (presence_detect_i),
        .addr_i                 (addr_i),
        .flash_bank_select_n_o  (flash_bank_select_n_o),
        .flash_access_clocks_o  (flash_access_clocks_o)
    );

    // presence detect shown to software as board status
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            board_status_pd_o <= 3'h0;
        end else begin
            board_status_pd_o <= presence_detect_i;
        end
    end

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    property p_cs_disabled;
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        !sdram_clock_enable_bit_i |=> sd_pins_o.cs_n && !sd_pins_o.cke;
    endproperty
    a_cs_disabled: assert property (p_cs_disabled) else $error("sdram on while disabled");

    property p_cs_follow;
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        (!sdram_region_select_n_i && sdram_clock_enable_bit_i) |=> !sd_pins_o.cs_n;
    endproperty
    a_cs_follow: assert property (p_cs_follow) else $error("sdram select not passed");

    property p_dqm;
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        1'b1 |=> sd_pins_o.dqm[3] == $past(byte_lane_strobes_n_i[0])
              && sd_pins_o.dqm[0] == $past(byte_lane_strobes_n_i[3]);
    endproperty
    a_dqm: assert property (p_dqm) else $error("byte lane mask order wrong");

    property p_strobes;
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        1'b1 |=> {sd_pins_o.ras_n, sd_pins_o.cas_n, sd_pins_o.we_n}
              == $past({general_line_one_n_i, general_line_two_n_i, general_line_three_n_i});
    endproperty
    a_strobes: assert property (p_strobes) else $error("command strobes misrouted");

    property p_bank;
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        1'b1 |=> sd_pins_o.bank == $past({addr_i[22], addr_i[21]});
    endproperty
    a_bank: assert property (p_bank) else $error("bank select not from A9 A10");

    property p_row_a10;
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        (row_phase_i && line_zero_addr_mode_i) |=> sd_pins_o.addr[10] == $past(addr_i[21]);
    endproperty
    a_row_a10: assert property (p_row_a10) else $error("row bit ten not A10");

    property p_row_map;
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        row_phase_i |=> sd_pins_o.addr[0] == $past(addr_i[10])
                     && sd_pins_o.addr[9] == $past(addr_i[19]);
    endproperty
    a_row_map: assert property (p_row_map) else $error("row address map wrong");

    property p_refresh_gap;
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        refresh_req_o |=> !refresh_req_o [*2];
    endproperty
    a_refresh_gap: assert property (p_refresh_gap) else $error("refresh too frequent");

endmodule

/* test/bsfi_mem_model.sv */
// bsfi_mem_model: behavioural sdram at the pins, keeps the mode word.
// assumes pins settle between rises of the sdram clock.
`timescale 1ns/1ps
module bsfi_mem_model (
    input  wire logic                    sdram_clk_i,
    input  wire bsfi_pkg::bsfi_sd_pins_t sd_pins_i,
    output logic [10:0]                  mode_o
);
    // ------------------------------------------------------------------
    // mode register set: all strobes low with the clock enabled
    // ------------------------------------------------------------------
    always @(posedge sdram_clk_i) begin
        if (sd_pins_i.cke && !(sd_pins_i.cs_n | sd_pins_i.ras_n |
                               sd_pins_i.cas_n | sd_pins_i.we_n)) begin
            mode_o <= sd_pins_i.addr;
        end
    end
endmodule

/* test/test_bsfi_top.sv */
// test_bsfi_top: self-checking bench for the sdram and flash glue.
// assumes a 200 MHz ref clock; inputs change at its falling edge.
`timescale 1ns/1ps
module test_bsfi_top;
    logic ref_clk_i, rst_n_i, bus_clock_output_i, row_phase_i, line_zero_addr_mode_i;
    logic general_line_zero_i, general_line_one_n_i, general_line_two_n_i;
    logic general_line_three_n_i, sdram_region_select_n_i, boot_region_select_n_i;
    logic sdram_clock_enable_bit_i, flash_disable_bit_i, bus_50mhz_i;
    logic sdram_clk_o, addr_mux_unsupported_o, refresh_req_o;
    logic [31:0] addr_i;
    logic [2:0]  address_multiplex_field_i, presence_detect_i, board_status_pd_o, refresh_beats_o;
    logic [3:0]  byte_lane_strobes_n_i, flash_bank_select_n_o, fl_exp;
    logic [4:0]  flash_access_clocks_o, last_sd_access_clocks_o, sd_read_clocks_o;
    logic [4:0]  sd_write_clocks_o, sd_refresh_clocks_o;
    logic [10:0] mode_w;
    bsfi_pkg::bsfi_sd_pins_t sd_pins_o;
    int          bad_count = 0, samples_checked = 0, pulses;
    bsfi_top #(.REFRESH_PERIOD_CYC(16)) dut_u (.ref_clk_i, .rst_n_i, .bus_clock_output_i,
        .addr_i, .row_phase_i, .address_multiplex_field_i, .line_zero_addr_mode_i,
        .general_line_zero_i, .general_line_one_n_i, .general_line_two_n_i,
        .general_line_three_n_i, .byte_lane_strobes_n_i, .sdram_region_select_n_i,
        .boot_region_select_n_i, .sdram_clock_enable_bit_i, .flash_disable_bit_i,
        .bus_50mhz_i, .presence_detect_i, .sdram_clk_o, .sd_pins_o, .addr_mux_unsupported_o,
        .flash_bank_select_n_o, .flash_access_clocks_o, .board_status_pd_o, .refresh_req_o,
        .refresh_beats_o, .last_sd_access_clocks_o, .sd_read_clocks_o, .sd_write_clocks_o,
        .sd_refresh_clocks_o);
    bsfi_mem_model mem_u (.sdram_clk_i(sdram_clk_o), .sd_pins_i(sd_pins_o), .mode_o(mode_w));
    // ------------------------------------------------------------------
    // clocks: ref clock, bus clock at half rate
    // ------------------------------------------------------------------
    initial begin
        ref_clk_i = 1'b0;
        forever #2.5 ref_clk_i = ~ref_clk_i;
    end
    always @(negedge ref_clk_i) bus_clock_output_i <= ~bus_clock_output_i;
    task automatic tick(input int n);
        repeat (n) @(negedge ref_clk_i);
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            bad_count++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // expected sdram pins from the present inputs
    function automatic logic [21:0] exp_pins();
        logic a10;
        a10 = (row_phase_i && line_zero_addr_mode_i) ? addr_i[21] : general_line_zero_i;
        return {~sdram_clock_enable_bit_i | sdram_region_select_n_i, general_line_one_n_i,
                general_line_two_n_i, general_line_three_n_i, sdram_clock_enable_bit_i,
                addr_i[22], addr_i[21], a10, row_phase_i ? addr_i[19:10] : addr_i[11:2],
                byte_lane_strobes_n_i[0], byte_lane_strobes_n_i[1],
                byte_lane_strobes_n_i[2], byte_lane_strobes_n_i[3]};
    endfunction
    // ------------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------------
    task automatic t_sdram();
        logic [31:0] adr [4] = '{32'h0040_0C00, 32'h0020_0400, 32'h0000_0FFC, 32'h0040_0C00};
        logic [7:0]  ctl [4] = '{8'hD1, 8'hD6, 8'h7E, 8'h80}; // row,mode,line0,en,strobes
        for (int i = 0; i < 4; i++) begin
            addr_i = adr[i];
            {row_phase_i, line_zero_addr_mode_i, general_line_zero_i, sdram_clock_enable_bit_i,
             byte_lane_strobes_n_i} = ctl[i];
            general_line_one_n_i = i[0];
            tick(1);
            check(sd_pins_o, exp_pins());
        end
        // only the zero multiplex code is supported; clock follows the bus clock
        {address_multiplex_field_i, sdram_clock_enable_bit_i} = {3'h1, 1'b1};
        #1 check(sdram_clk_o, bus_clock_output_i);
        check(addr_mux_unsupported_o, 1'b1);
        tick(1);
        address_multiplex_field_i = 3'h0;
        #1 check(sdram_clk_o, bus_clock_output_i);
        check(addr_mux_unsupported_o, 1'b0);
        tick(1);
        // host sets the mode first, for 50 MHz and then for 25 MHz
        {general_line_one_n_i, general_line_two_n_i, general_line_three_n_i} = 3'h0;
        {addr_i, row_phase_i, general_line_zero_i} = {32'h0000_0088, 2'b00};
        tick(4);
        check(mode_w, 11'h022);
        addr_i = 32'h0000_0048;
        tick(4);
        check(mode_w, 11'h012);
        {general_line_one_n_i, general_line_two_n_i, general_line_three_n_i} = 3'h7;
        // a select of ten ref cycles spans five bus clock rises
        sdram_region_select_n_i = 1'b1;
        tick(2);
        sdram_region_select_n_i = 1'b0;
        tick(10);
        sdram_region_select_n_i = 1'b1;
        tick(2);
        check(last_sd_access_clocks_o, 5'h05);
        sdram_region_select_n_i = 1'b0;
        check(sd_read_clocks_o, 5'h05);
        check(sd_write_clocks_o, 5'h04);
        check(sd_refresh_clocks_o, 5'h15);
        $display("test sdram done");
    endtask
    task automatic t_flash();
        logic [1:0] idx;
        {boot_region_select_n_i, addr_i} = {1'b0, 32'h0060_0000};
        for (int i = 0; i < 16; i++) begin
            {bus_50mhz_i, presence_detect_i} = i[3:0];
            flash_disable_bit_i = (i == 5);
            tick(1);
            idx = (presence_detect_i[1:0] == 2'h0) ? 2'h0 :
                  (presence_detect_i[1:0] == 2'h1) ? {1'b0, addr_i[21]} : addr_i[22:21];
            fl_exp = flash_disable_bit_i ? 4'hF : ~(4'h1 << idx);
            check(flash_bank_select_n_o, fl_exp);
            check(flash_access_clocks_o, bus_50mhz_i ? (presence_detect_i[2] ? 5'h0A : 5'h08)
                                         : (presence_detect_i[2] ? 5'h05 : 5'h04));
            check(board_status_pd_o, presence_detect_i);
        end
        // host keeps reading; the bank select holds for three more cycles
        repeat (3) begin
            tick(1);
            check(flash_bank_select_n_o, fl_exp);
        end
        boot_region_select_n_i = 1'b1;
        tick(1);
        check(flash_bank_select_n_o, 4'hF);
        $display("test flash done");
    endtask
    task automatic t_refresh(input logic en, input int exp);
        sdram_clock_enable_bit_i = en;
        tick(2);
        pulses = 0;
        repeat (64) begin
            tick(1);
            pulses += (refresh_req_o === 1'b1);
        end
        check(pulses, exp);
        check(refresh_beats_o, 3'h4);
        $display("test refresh done");
    endtask
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    initial begin
        #5000;
        bad_count++;
        give_verdict();
    end
    initial begin
        {rst_n_i, bus_clock_output_i, row_phase_i, line_zero_addr_mode_i, general_line_zero_i} = 0;
        {general_line_one_n_i, general_line_two_n_i, general_line_three_n_i} = 3'h7;
        {sdram_region_select_n_i, boot_region_select_n_i, flash_disable_bit_i} = 3'h7;
        {sdram_clock_enable_bit_i, bus_50mhz_i, addr_i} = 0;
        {address_multiplex_field_i, presence_detect_i, byte_lane_strobes_n_i} = 0;
        tick(10);
        check(sd_pins_o, 22'h3C000F);
        rst_n_i = 1'b1;
        {sdram_region_select_n_i, boot_region_select_n_i} = 2'b00;
        t_sdram();
        t_flash();
        t_refresh(1'b1, 4);
        t_refresh(1'b0, 0);
        give_verdict();
    end
endmodule
